// *** hdl/connection_switch.sv ***
/*
  Connection entry and slot switch with an AHB-Lite register slave.
  Assumes one slot per clock, din matching in_slot, and a single bus master.
*/
// Local design decision: the AHB-Lite slave port.
//
// Overview of operation
// - sixteen-bit entry word, cleared after reset
// - memory select set: entry read and write
// - low three source bits pick input multiplex
// - next five source bits pick input timeslot
// - generator select ignores source half, uses generator
// - memory select clear: source half shows data
// - integrity: delay is (32-its)+32+ots timeslots
// - no integrity: smallest delay through data memory
// - loopback takes output slot as source
// - transparent bit picks transparent or idle loopback
// - source 00 data memory, 01 entry itself
// - source 10 switches GCI D channels
// - source 11 takes pseudo-random generator
// - upstream always, downstream when its bit2 set
// - changing source drops upstream D connection
// - its low bits choose GCI channel group
// - its bit3 clear: ascending pairs from 1/2
// - downstream uses same-numbered input timeslot
// - its bit3 set: reversed pair order
`timescale 1ns/100ps
`default_nettype none
module connection_switch (
  input wire logic hclk, // bus and switch clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // word transfers only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic [31:0] hrdata, // read data
  output logic hresp, // always okay
  input wire logic [7:0] din, // byte of slot in_slot
  output logic [7:0] in_slot, // slot expected on din
  input wire logic [15:0] first_gci_input, // D bits, first gci
  input wire logic [15:0] second_gci_input, // D bits, second gci
  output logic [7:0] dout, // switched byte
  output logic [7:0] out_slot, // slot of dout
  output logic [15:0] first_gci_output, // D bits, first gci
  output logic [15:0] second_gci_output // D bits, second gci
);
  import tsw_pkg::*;

  ram_port_if #(.AW(8), .DW(16)) conn_mem ();
  ram_port_if #(.AW(10), .DW(8)) dm ();

  state_t state, next_state;
  logic [7:0] init_ctr, next_init_ctr;
  logic [7:0] slot_ctr, next_slot_ctr;
  logic [1:0] page, next_page;
  logic wr_pend, next_wr_pend;
  logic [7:0] ap_addr, next_ap_addr;
  logic [1:0] rd_stage, next_rd_stage;
  logic [ADDR_REG_W-1:0] addr_reg, next_addr_reg;
  logic next_hreadyout;
  logic [31:0] next_hrdata;
  logic take, addr_ok;
  logic [7:0] target_slot;
  logic [7:0] s1_slot, next_s1_slot;
  logic [1:0] s1_page, next_s1_page;
  logic [7:0] s2_slot, next_s2_slot;
  logic [15:0] s2_entry, next_s2_entry;
  logic [7:0] s2_up, next_s2_up;
  logic [14:0] prs, next_prs;
  logic [7:0] next_dout, next_out_slot;
  logic [15:0] next_gci_a, next_gci_b, map_a, map_b;
  logic [7:0] up_byte;
  logic [7:0] src_slot;
  logic [1:0] back;
  src_t e_src, s2_src;

  dual_read_ram u_conn_mem (.clk(hclk), .port(conn_mem.store));
  dual_read_ram u_dm (.clk(hclk), .port(dm.store));

  dchan_map u_map (
    .up_its(conn_mem.rdata_b[3:0]),
    .down_its(s2_entry[3:0]),
    .gci_in_a(first_gci_input),
    .gci_in_b(second_gci_input),
    .down_byte(dm.rdata_b),
    .gci_out_a(first_gci_output),
    .gci_out_b(second_gci_output),
    .up_byte(up_byte),
    .next_out_a(map_a),
    .next_out_b(map_b)
  );

  // bus slave and address register
  assign take = hsel && hready && htrans[1];
  assign addr_ok = (haddr[31:8] == 24'h000000) && (hsize == 3'h2);
  assign target_slot = slot_of(addr_reg[4:0], addr_reg[7:5]);

  always_comb begin
    next_wr_pend = take && hwrite;
    next_ap_addr = take ? (addr_ok ? haddr[7:0] : 8'h00) : ap_addr;
    next_rd_stage = {rd_stage[0], take && !hwrite};
    next_addr_reg = addr_reg;
    if (wr_pend && ap_addr == ADDR_REG_ADDR) begin
      next_addr_reg = hwdata[ADDR_REG_W-1:0];
    end
    // reads wait two cycles so a just-written address is seen
    next_hreadyout = (state == ST_RUN) && !(take && !hwrite) && !rd_stage[0];
    if (state == ST_CLEAR) begin
      next_hreadyout = (init_ctr == LAST_SLOT);
    end
    next_hrdata = hrdata;
    if (rd_stage[1]) begin
      unique case (ap_addr)
        ADDR_REG_ADDR: next_hrdata = {21'h0, addr_reg};
        ENTRY_ADDR: next_hrdata = {16'h0000, conn_mem.rdata_a[15:8],
                                   addr_reg[MSEL_BIT] ? conn_mem.rdata_a[7:0] : dm.rdata_a};
        default: next_hrdata = 32'h00000000;
      endcase
    end
  end

  // reset sweep of connection memory, then run
  always_comb begin
    next_state = state;
    next_init_ctr = init_ctr;
    unique case (state)
      ST_CLEAR: begin
        next_init_ctr = 8'(init_ctr + 8'h01);
        if (init_ctr == LAST_SLOT) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: next_init_ctr = init_ctr;
      default: next_state = ST_CLEAR;
    endcase
  end

  // connection memory ports
  always_comb begin
    conn_mem.we = 1'b0;
    conn_mem.waddr = target_slot;
    conn_mem.wdata = ENTRY_RESET;
    conn_mem.raddr_a = target_slot;
    conn_mem.raddr_b = slot_ctr;
    if (state == ST_CLEAR) begin
      conn_mem.we = 1'b1;
      conn_mem.waddr = init_ctr;
    end else if (wr_pend && ap_addr == ENTRY_ADDR && addr_reg[MSEL_BIT]) begin
      conn_mem.we = 1'b1;
      conn_mem.wdata = hwdata[15:0];
      if (addr_reg[GSEL_BIT]) begin
        conn_mem.wdata = {hwdata[15:13], SRC_PRS, hwdata[10:8], 8'h00};
      end
    end
  end

  // slot stage 1: entry is out, pick the data memory word
  assign e_src = src_t'(conn_mem.rdata_b[SRC_LSB +: 2]);
  always_comb begin
    src_slot = conn_mem.rdata_b[7:0];
    if (conn_mem.rdata_b[LOOP_BIT] || e_src == SRC_GCI) begin
      src_slot = s1_slot;
    end
    back = (src_slot <= s1_slot) ? 2'h0 : VD_PAGE_BACK;
    if (conn_mem.rdata_b[SI_BIT]) begin
      back = SI_PAGE_BACK;
    end
    dm.we = 1'b1;
    dm.waddr = {page, slot_ctr};
    dm.wdata = din;
    dm.raddr_a = {2'(page - VD_PAGE_BACK), target_slot};
    dm.raddr_b = {2'(s1_page - back), src_slot};
  end

  // slot stage 2: data is out, choose the output
  assign s2_src = src_t'(s2_entry[SRC_LSB +: 2]);
  always_comb begin
    next_slot_ctr = 8'(slot_ctr + 8'h01);
    next_page = (slot_ctr == LAST_SLOT) ? 2'(page + 2'h1) : page;
    next_s1_slot = slot_ctr;
    next_s1_page = page;
    next_s2_slot = s1_slot;
    next_s2_entry = conn_mem.rdata_b;
    next_s2_up = up_byte;
    next_prs = prs;
    next_out_slot = s2_slot;
    next_gci_a = first_gci_output;
    next_gci_b = second_gci_output;
    unique case (s2_src)
      SRC_DATA: begin
        next_dout = dm.rdata_b;
        if (s2_entry[LOOP_BIT] && !s2_entry[TRANSP_BIT]) begin
          next_dout = IDLE_BYTE;
        end
      end
      SRC_CONN: next_dout = s2_entry[7:0];
      SRC_GCI: begin
        next_dout = s2_up;
        if (s2_entry[ITS_DOWN_BIT]) begin
          next_gci_a = map_a;
          next_gci_b = map_b;
        end
      end
      SRC_PRS: begin
        next_prs = prs_step8(prs);
        next_dout = next_prs[7:0];
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_CLEAR;
      init_ctr <= 8'h00;
      wr_pend <= 1'b0;
      ap_addr <= 8'h00;
      rd_stage <= 2'h0;
      addr_reg <= ADDR_REG_RESET;
      hreadyout <= 1'b0;
      hrdata <= 32'h00000000;
      hresp <= 1'b0;
      slot_ctr <= 8'h00;
      page <= 2'h0;
      s1_slot <= 8'h00;
      s1_page <= 2'h0;
      s2_slot <= 8'h00;
      s2_entry <= ENTRY_RESET;
      s2_up <= 8'h00;
      prs <= PRS_SEED;
      dout <= 8'h00;
      out_slot <= 8'h00;
      first_gci_output <= 16'h0000;
      second_gci_output <= 16'h0000;
    end else begin
      state <= next_state;
      init_ctr <= next_init_ctr;
      wr_pend <= next_wr_pend;
      ap_addr <= next_ap_addr;
      rd_stage <= next_rd_stage;
      addr_reg <= next_addr_reg;
      hreadyout <= next_hreadyout;
      hrdata <= next_hrdata;
      hresp <= 1'b0;
      slot_ctr <= next_slot_ctr;
      page <= next_page;
      s1_slot <= next_s1_slot;
      s1_page <= next_s1_page;
      s2_slot <= next_s2_slot;
      s2_entry <= next_s2_entry;
      s2_up <= next_s2_up;
      prs <= next_prs;
      dout <= next_dout;
      out_slot <= next_out_slot;
      first_gci_output <= next_gci_a;
      second_gci_output <= next_gci_b;
    end
  end

  assign in_slot = slot_ctr;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_read_wait;
    (state == ST_RUN) && take && !hwrite |=> !hreadyout ##1 !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait states wrong");

  property p_gen_store;
    conn_mem.we && state == ST_RUN && addr_reg[GSEL_BIT]
      |-> conn_mem.wdata[7:0] == 8'h00 && conn_mem.wdata[SRC_LSB +: 2] == SRC_PRS;
  endproperty
  a_gen_store: assert property (p_gen_store) else $error("generator entry not forced");

  property p_dm_readonly;
    wr_pend && ap_addr == ENTRY_ADDR && !addr_reg[MSEL_BIT] && state == ST_RUN |-> !conn_mem.we;
  endproperty
  a_dm_readonly: assert property (p_dm_readonly) else $error("data window was written");

  property p_si_page;
    conn_mem.rdata_b[SI_BIT] |-> dm.raddr_b[9:8] == 2'(s1_page - 2'h2);
  endproperty
  a_si_page: assert property (p_si_page) else $error("integrity page wrong");

  property p_vd_page;
    !conn_mem.rdata_b[SI_BIT] && !conn_mem.rdata_b[LOOP_BIT] && e_src == SRC_DATA
      && conn_mem.rdata_b[7:0] <= s1_slot |-> dm.raddr_b == {s1_page, conn_mem.rdata_b[7:0]};
  endproperty
  a_vd_page: assert property (p_vd_page) else $error("variable delay not minimal");

  property p_loop_src;
    conn_mem.rdata_b[LOOP_BIT] |-> dm.raddr_b[7:0] == s1_slot;
  endproperty
  a_loop_src: assert property (p_loop_src) else $error("loopback source wrong");

  property p_conn_out;
    s2_src == SRC_CONN |=> dout == $past(s2_entry[7:0]) && out_slot == $past(s2_slot);
  endproperty
  a_conn_out: assert property (p_conn_out) else $error("entry byte not output");

  property p_idle_loop;
    s2_src == SRC_DATA && s2_entry[LOOP_BIT] && !s2_entry[TRANSP_BIT] |=> dout == IDLE_BYTE;
  endproperty
  a_idle_loop: assert property (p_idle_loop) else $error("non-transparent loop leaked");

  property p_down_hold;
    !(s2_src == SRC_GCI && s2_entry[ITS_DOWN_BIT])
      |=> $stable(first_gci_output) && $stable(second_gci_output);
  endproperty
  a_down_hold: assert property (p_down_hold) else $error("gci output moved unasked");

  property p_prs_adv;
    s2_src != SRC_PRS |=> prs == $past(prs);
  endproperty
  a_prs_adv: assert property (p_prs_adv) else $error("generator stepped idle");
endmodule // connection_switch
`default_nettype wire

// *** hdl/tsw_pkg.sv ***
/*
  Shared constants, types and helpers of the timeslot connection switch.
  Assumes one 40 MHz bus clock and 256 slots (32 timeslots x 8 multiplexes).
*/
package tsw_pkg;
  // register map: printed offsets are word indexes, byte address is four times
  localparam logic [7:0] ENTRY_INDEX = 8'h0E;
  localparam logic [7:0] ADDR_REG_INDEX = 8'h0D;
  localparam logic [7:0] ENTRY_ADDR = {ENTRY_INDEX[5:0], 2'h0};
  localparam logic [7:0] ADDR_REG_ADDR = {ADDR_REG_INDEX[5:0], 2'h0};
  // address register layout
  localparam int ADDR_REG_W = 11;
  localparam int MSEL_BIT = 8;
  localparam int BID_BIT = 9;
  localparam int GSEL_BIT = 10;
  localparam logic [10:0] ADDR_REG_RESET = 11'h000;
  // connection entry layout
  localparam int SI_BIT = 8;
  localparam int LOOP_BIT = 9;
  localparam int TRANSP_BIT = 10;
  localparam int SRC_LSB = 11;
  localparam int ITS_DOWN_BIT = 2;
  localparam int ITS_REV_BIT = 3;
  localparam logic [15:0] ENTRY_RESET = 16'h0000;
  // data memory paging: four frame pages
  localparam logic [1:0] SI_PAGE_BACK = 2'h2;
  localparam logic [1:0] VD_PAGE_BACK = 2'h1;
  localparam logic [7:0] LAST_SLOT = 8'hFF;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  localparam logic [14:0] PRS_SEED = 15'h7FFF;

  typedef enum logic [1:0] {
    SRC_DATA = 2'h0,
    SRC_CONN = 2'h1,
    SRC_GCI = 2'h2,
    SRC_PRS = 2'h3
  } src_t;

  typedef enum logic [1:0] {
    ST_CLEAR = 2'h1,
    ST_RUN = 2'h2
  } state_t;

  // slot index is timeslot-major, multiplex-minor
  function automatic logic [7:0] slot_of(input logic [4:0] ts, input logic [2:0] mux);
    return {ts, mux};
  endfunction

  // low bit of the byte pair carrying the k-th selected D channel
  function automatic logic [2:0] pair_lsb(input logic [1:0] k, input logic rev);
    return rev ? {k, 1'b0} : 3'(3'h6 - {k, 1'b0});
  endfunction

  // eight steps of x^15 + x^14 + 1
  function automatic logic [14:0] prs_step8(input logic [14:0] s);
    logic [14:0] v;
    v = s;
    for (int i = 0; i < 8; i++) begin
      v = {v[13:0], v[14] ^ v[13]};
    end
    return v;
  endfunction
endpackage

// *** hdl/ram_port_if.sv ***
/*
  Port bundle of a one-write, two-read memory.
  Assumes the owner drives addresses and write data; the store answers reads.
*/
`timescale 1ns/100ps
`default_nettype none
interface ram_port_if #(parameter int AW = 8, parameter int DW = 8);
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr_a;
  logic [DW-1:0] rdata_a;
  logic [AW-1:0] raddr_b;
  logic [DW-1:0] rdata_b;
  modport owner (output we, waddr, wdata, raddr_a, raddr_b, input rdata_a, rdata_b);
  modport store (input we, waddr, wdata, raddr_a, raddr_b, output rdata_a, rdata_b);
endinterface // ram_port_if
`default_nettype wire

// *** hdl/dual_read_ram.sv ***
/*
  Memory with one write port and two registered read ports.
  Assumes a read of an address written at the same edge returns the old word.
*/
`timescale 1ns/100ps
`default_nettype none
module dual_read_ram (
  input wire logic clk, // memory clock
  ram_port_if.store port // write and read ports
);
  localparam int AW = $bits(port.waddr);
  logic [$bits(port.wdata)-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (port.we) begin
      mem[port.waddr] <= port.wdata;
    end
    port.rdata_a <= mem[port.raddr_a];
    port.rdata_b <= mem[port.raddr_b];
  end
endmodule // dual_read_ram
`default_nettype wire

// *** hdl/dchan_map.sv ***
/*
  D channel packing: four GCI D channels to one byte, and back.
  Assumes each GCI word carries channel c in bits 2c+1:2c.
*/
`timescale 1ns/100ps
`default_nettype none
module dchan_map
  import tsw_pkg::*;
(
  input wire logic [3:0] up_its, // upstream timeslot field
  input wire logic [3:0] down_its, // downstream timeslot field
  input wire logic [15:0] gci_in_a, // first gci input D bits
  input wire logic [15:0] gci_in_b, // second gci input D bits
  input wire logic [7:0] down_byte, // byte to spread downstream
  input wire logic [15:0] gci_out_a, // first gci output now
  input wire logic [15:0] gci_out_b, // second gci output now
  output logic [7:0] up_byte, // packed upstream byte
  output logic [15:0] next_out_a, // first gci output after spread
  output logic [15:0] next_out_b // second gci output after spread
);
  always_comb begin
    logic [15:0] src;
    logic [3:0] ch;
    logic [1:0] bits;
    src = up_its[1] ? gci_in_b : gci_in_a;
    ch = 4'h0;
    bits = 2'h0;
    up_byte = 8'h00;
    next_out_a = gci_out_a;
    next_out_b = gci_out_b;
    for (int k = 0; k < 4; k++) begin
      ch = {up_its[0], 2'(k), 1'b0};
      up_byte[pair_lsb(2'(k), up_its[ITS_REV_BIT]) +: 2] = src[ch +: 2];
      ch = {down_its[0], 2'(k), 1'b0};
      bits = down_byte[pair_lsb(2'(k), down_its[ITS_REV_BIT]) +: 2];
      if (down_its[1]) begin
        next_out_b[ch +: 2] = bits;
      end else begin
        next_out_a[ch +: 2] = bits;
      end
    end
  end
endmodule // dchan_map
`default_nettype wire

// *** bench/tsw_far_end.sv ***
/*
  Far side of the switch: TDM source feeding din and two GCI multiplexes.
  Assumes in_slot counts slots as the switch expects them, one per clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tsw_far_end (
  input wire logic hclk, // switch clock
  input wire logic hresetn, // async reset, active low
  input wire logic [7:0] in_slot, // slot the switch expects
  input wire logic [15:0] gci_a_set, // D bits offered on first gci
  input wire logic [15:0] gci_b_set, // D bits offered on second gci
  output logic [7:0] din, // byte of in_slot
  output logic [15:0] gci_a, // first gci input
  output logic [15:0] gci_b, // second gci input
  output logic [7:0] frame_no // frames seen since reset
);
  // frame tag folded into each byte so a stale page shows up
  assign din = in_slot ^ {frame_no[3:0], frame_no[3:0]};
  assign gci_a = gci_a_set;
  assign gci_b = gci_b_set;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_no <= 8'h00;
    end else if (in_slot == 8'hFF) begin
      frame_no <= frame_no + 8'h01;
    end
  end
endmodule // tsw_far_end
`default_nettype wire

// *** bench/tb_connection_switch.sv ***
/*
  Self-checking bench of the connection switch.
  Assumes tsw_far_end feeds din with frame-tagged bytes and steady gci bits.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_connection_switch;
  import tsw_pkg::*;
  localparam logic [7:0] OSLOT = 8'h9A;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] gci_a_set = 16'hE41B;
  logic [15:0] gci_b_set = 16'h72D8;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [7:0] din, in_slot, dout, out_slot, frame_no;
  logic [15:0] gci_a, gci_b, gout_a, gout_b;
  int miscompares = 0;
  int checks = 0;

  always #12.5 hclk = ~hclk;

  connection_switch u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .din(din), .in_slot(in_slot),
    .first_gci_input(gci_a), .second_gci_input(gci_b), .dout(dout), .out_slot(out_slot),
    .first_gci_output(gout_a), .second_gci_output(gout_b));
  tsw_far_end u_far (.hclk(hclk), .hresetn(hresetn), .in_slot(in_slot), .gci_a_set(gci_a_set),
    .gci_b_set(gci_b_set), .din(din), .gci_a(gci_a), .gci_b(gci_b), .frame_no(frame_no));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // waits on hready only; the watchdog bounds a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic prog(input logic [2:0] fl, input logic [15:0] e);
    logic [31:0] r;
    xfer(1'b1, ADDR_REG_ADDR, {21'h0, fl, OSLOT[2:0], OSLOT[7:3]}, r);
    xfer(1'b1, ENTRY_ADDR, {16'h0, e}, r);
  endtask

  function automatic logic [7:0] pat(input logic [7:0] s, input logic [7:0] f);
    return s ^ {f[3:0], f[3:0]};
  endfunction

  // second occurrence, so an entry written mid-slot has surely taken hold
  task automatic watch(output logic [7:0] b, output logic [7:0] f);
    int seen;
    seen = 0;
    while (seen < 2) begin
      @(posedge hclk);
      #1;
      if (out_slot === OSLOT) begin
        seen++;
      end
    end
    b = dout;
    f = frame_no - {7'h0, in_slot < out_slot};
  endtask

  task automatic t_regs;
    logic [31:0] r;
    xfer(1'b1, ADDR_REG_ADDR, {21'h0, 3'b001, OSLOT[2:0], OSLOT[7:3]}, r);
    xfer(1'b0, ENTRY_ADDR, 32'h0, r);
    cmp(r, 32'h0);
    xfer(1'b0, 8'hF0, 32'h0, r);
    cmp(r, 32'h0);
    prog(3'b001, 16'hE7A5);
    xfer(1'b0, ENTRY_ADDR, 32'h0, r);
    cmp(r, 32'hE7A5);
    prog(3'b000, 16'h1234);
    xfer(1'b0, ENTRY_ADDR, 32'h0, r);
    cmp({24'h0, r[15:8]}, 32'hE7);
    r[7:0] = r[7:0] ^ OSLOT;
    cmp({28'h0, r[7:4]}, {28'h0, r[3:0]});
  endtask

  task automatic t_route;
    logic [7:0] b, f, s, fs;
    for (int i = 0; i < 4; i++) begin
      s = i[0] ? 8'hE6 : 8'h29;
      prog(3'b001, {7'h0, i[1], s});
      watch(b, f);
      fs = i[1] ? f - 8'h02 : (s <= OSLOT ? f : f - 8'h01);
      cmp({24'h0, b}, {24'h0, pat(s, fs)});
    end
  endtask

  task automatic t_loop;
    logic [7:0] b, f;
    prog(3'b001, 16'h06E6);
    watch(b, f);
    cmp({24'h0, b}, {24'h0, pat(OSLOT, f)});
    prog(3'b001, 16'h02E6);
    watch(b, f);
    cmp({24'h0, b}, 32'hFF);
  endtask

  task automatic t_gen;
    logic [7:0] b, f, b1;
    logic [31:0] r;
    prog(3'b001, 16'h085C);
    watch(b, f);
    cmp({24'h0, b}, 32'h5C);
    prog(3'b101, 16'h0129);
    xfer(1'b0, ENTRY_ADDR, 32'h0, r);
    cmp(r, 32'h1900);
    watch(b, f);
    watch(b1, f);
    cmp({31'h0, b1 == b}, 32'h0);
  endtask

  task automatic t_gci;
    logic [7:0] b, f, e;
    logic [3:0] its;
    logic [15:0] g;
    for (int i = 0; i < 8; i++) begin
      its = {i[2], 1'b0, i[1], i[0]};
      prog(3'b001, {8'h10, 4'h0, its});
      watch(b, f);
      g = its[1] ? gci_b_set : gci_a_set;
      for (int k = 0; k < 4; k++) begin
        if (its[3]) begin
          e[2*k+1 -: 2] = g[2*(4*its[0]+k)+1 -: 2];
        end else begin
          e[7-2*k -: 2] = g[2*(4*its[0]+k)+1 -: 2];
        end
      end
      cmp({24'h0, b}, {24'h0, e});
    end
  endtask

  task automatic t_down;
    logic [7:0] b, f;
    logic [15:0] h;
    prog(3'b001, 16'h1004);
    watch(b, f);
    watch(b, f);
    for (int k = 0; k < 4; k++) begin
      b[7-2*k -: 2] = gout_a[2*k+1 -: 2];
    end
    b = b ^ OSLOT;
    cmp({28'h0, b[7:4]}, {28'h0, b[3:0]});
    cmp({8'h0, gout_a[15:8], gout_b}, 32'h0);
    prog(3'b001, 16'h1000);
    watch(b, f);
    h = gout_a;
    watch(b, f);
    cmp({16'h0, gout_a}, {16'h0, h});
    prog(3'b001, 16'h0029);
    watch(b, f);
    cmp({24'h0, b}, {24'h0, pat(8'h29, f)});
  endtask

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_route();
    t_loop();
    t_gen();
    t_gci();
    t_down();
    test_done();
  end

  // 22 watched frame pairs plus the reset sweep fit well inside this
  initial begin
    repeat (40000) @(posedge hclk);
    miscompares++;
    test_done();
  end
endmodule // tb_connection_switch
`default_nettype wire
